// ---- src/flash_host_pkg.sv ----
// constants shared by the flash host controller
package flash_host_pkg;
	localparam int CLK_HZ = 25000000;
	localparam int CLK_NS = 40;
	// pin timing, nanoseconds
	localparam int RESET_PULSE_MIN_NS = 500;
	localparam int RESET_HIGH_TO_READ_NS = 50;
	localparam int STROBE_NS = 80;
	localparam int READ_ACCESS_NS = 120;
	localparam int RESET_PULSE_CYC = (RESET_PULSE_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int RESET_HIGH_CYC = (RESET_HIGH_TO_READ_NS + CLK_NS - 1) / CLK_NS;
	localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
	localparam int READ_CYC = (READ_ACCESS_NS + CLK_NS - 1) / CLK_NS;
	// command codes
	localparam logic [7:0] CODE_UNLOCK1 = 8'haa;
	localparam logic [7:0] CODE_UNLOCK2 = 8'h55;
	localparam logic [7:0] CODE_ERASE_SETUP = 8'h80;
	localparam logic [7:0] CODE_CHIP_ERASE = 8'h10;
	localparam logic [7:0] CODE_SECTOR_ERASE = 8'h30;
	localparam logic [7:0] CODE_IDENT = 8'h90;
	localparam logic [7:0] CODE_PROGRAM = 8'ha0;
	localparam logic [7:0] CODE_RESET = 8'hf0;
	localparam logic [7:0] CODE_UNLOCK_BYPASS = 8'h20;
	localparam logic [11:0] ADDR_WORD_A = 12'h555;
	localparam logic [11:0] ADDR_WORD_B = 12'h2aa;
	localparam logic [11:0] ADDR_BYTE_A = 12'haaa;
	localparam logic [11:0] ADDR_BYTE_B = 12'h555;
	// status bit positions on the data bus
	localparam int COMPLETION_POLL_BIT = 7;
	localparam int TOGGLE_STATUS_BIT = 6;
	localparam int TIMEOUT_FAIL_BIT = 5;
	// software register offsets
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_ADDR = 4'h1;
	localparam logic [3:0] REG_DATA = 4'h2;
	localparam logic [3:0] REG_STATUS = 4'h3;
	localparam logic [3:0] REG_RDATA = 4'h4;
	// command field values in REG_CTRL[3:0]
	localparam logic [3:0] OP_READ = 4'h0;
	localparam logic [3:0] OP_PROGRAM = 4'h1;
	localparam logic [3:0] OP_CHIP_ERASE = 4'h2;
	localparam logic [3:0] OP_SECTOR_ERASE = 4'h3;
	localparam logic [3:0] OP_IDENT = 4'h4;
	localparam logic [3:0] OP_RESET_CMD = 4'h5;
	localparam logic [3:0] OP_HW_RESET = 4'h6;
	localparam logic [3:0] OP_BYPASS_ENTER = 4'h7;
	localparam logic [3:0] OP_BYPASS_PROGRAM = 4'h8;
	localparam logic [3:0] OP_POLL = 4'h9;
	localparam int CTRL_BYTE_MODE_BIT = 8;
	localparam int RESET_HOLD_CYC = 16;
endpackage

// ---- src/flash_bus_cycle.sv ----
// one read or write strobe cycle on the flash pins
`timescale 1ns/1ns
`default_nettype none
module flash_bus_cycle #(
	parameter int STROBE_CYCLES = 2,
	parameter int READ_CYCLES = 3
) (
	input wire logic clk, // system clock
	input wire logic resetn, // synchronous reset, low
	input wire logic start, // begin a cycle
	input wire logic is_write, // 1 write, 0 read
	output logic busy, // cycle in progress
	output logic done, // one-cycle end pulse
	output logic ce_n, // chip select
	output logic we_n, // write strobe
	output logic oe_n, // output gate
	output logic dq_oe // host drives data
);
	localparam int W = $clog2(STROBE_CYCLES + READ_CYCLES + 2);
	initial
	begin
		if (STROBE_CYCLES < 1 || READ_CYCLES < 1)
			$error("flash_bus_cycle: counts must be at least one");
	end
	typedef enum logic [1:0] {CY_IDLE, CY_SETUP, CY_STROBE, CY_END} cyc_state_t;
	cyc_state_t st_q, st_d;
	logic [W-1:0] cnt_q, cnt_d;
	logic wr_q, wr_d;
	always_comb
	begin
		st_d = st_q;
		cnt_d = cnt_q;
		wr_d = wr_q;
		case (st_q)
			CY_IDLE:
				if (start)
				begin
					wr_d = is_write;
					st_d = CY_SETUP;
				end
			CY_SETUP:
			begin
				st_d = CY_STROBE;
				cnt_d = W'(wr_q ? STROBE_CYCLES - 1 : READ_CYCLES - 1);
			end
			CY_STROBE:
				if (cnt_q == '0)
					st_d = CY_END;
				else
					cnt_d = cnt_q - 1'b1;
			CY_END:
				st_d = CY_IDLE;
			default:
				st_d = CY_IDLE;
		endcase
	end
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			st_q <= CY_IDLE;
			cnt_q <= '0;
			wr_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			wr_q <= wr_d;
		end
	end
	// write keeps gate high through the cycle; data driven setup to end
	assign busy = (st_q != CY_IDLE);
	assign done = (st_q == CY_END);
	assign ce_n = !(st_q == CY_SETUP || st_q == CY_STROBE);
	assign we_n = !(wr_q && st_q == CY_STROBE); // [RULE1]
	assign oe_n = !(!wr_q && st_q == CY_STROBE); // [RULE1]
	assign dq_oe = wr_q && (st_q != CY_IDLE);
endmodule // flash_bus_cycle
`default_nettype wire

// ---- src/flash_reset_timer.sv ----
// drives the hardware reset pin and the recovery wait
`timescale 1ns/1ns
`default_nettype none
module flash_reset_timer #(
	parameter int PULSE_CYCLES = 13,
	parameter int RECOVER_CYCLES = 2
) (
	input wire logic clk, // system clock
	input wire logic resetn, // synchronous reset, low
	input wire logic start, // request a reset pulse
	output logic reset_n_pin, // reset pin level
	output logic busy // pulse or recovery running
);
	localparam int W = $clog2(PULSE_CYCLES + RECOVER_CYCLES + 2);
	initial
	begin
		if (PULSE_CYCLES < 1 || RECOVER_CYCLES < 1)
			$error("flash_reset_timer: counts must be at least one");
	end
	logic [W-1:0] cnt_q, cnt_d;
	logic low_q, low_d;
	always_comb
	begin
		cnt_d = cnt_q;
		low_d = low_q;
		if (start && cnt_q == '0)
		begin
			low_d = 1'b1;
			cnt_d = W'(PULSE_CYCLES);
		end
		else if (cnt_q != '0)
		begin
			cnt_d = cnt_q - 1'b1;
			if (low_q && cnt_q == W'(1))
			begin
				low_d = 1'b0;
				cnt_d = W'(RECOVER_CYCLES); // [RULE8]
			end
		end
	end
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			cnt_q <= '0;
			low_q <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			low_q <= low_d;
		end
	end
	assign reset_n_pin = !low_q; // [RULE6]
	assign busy = (cnt_q != '0);
endmodule // flash_reset_timer
`default_nettype wire

// ---- src/flash_host_ctrl.sv ----
// host controller that drives a parallel flash through its strobe pins
// Contract
// [RULE1] writes: strobe and select low, gate high
// [RULE2] bypass mode programs in two writes
// [RULE3] bad sequence drops device to array read
// [RULE4] identifier codes on low byte, normal reads
// [RULE5] gate high floats device data pins
// [RULE6] reset pulse held at least minimum time
// [RULE7] device holds done pin busy during reset
// [RULE8] wait reset-high-to-read before reading
// [RULE9] reset code after failure, then new command
// [RULE10] id select bits pick maker or device code
// [RULE11] protect check reads one or zero
// [RULE12] erase is six cycles, 80 then 10/30
// [RULE13] unlock addresses differ for word, byte
// [RULE14] chip erase self-timed, no host control
// [RULE15] erase starts on last strobe rise
// [RULE16] done when poll bit 1, toggle stops; code checks the toggle bit only
// [RULE17] timeout fail bit marks erase failure
// [RULE18] device powers up in array read
// [RULE19] suspended sectors read status, not data
// [RULE20] reset command after fail or identifier mode
// [RULE21] reset command address is don't care
// [RULE22] reset mid erase sequence aborts it
// [RULE23] reset mid program sequence aborts it
// [RULE24] identifier mode left only by reset
// [RULE25] word mode id upper byte fixed
// [RULE26] decoder tracks position, latches on strobe
//
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/1ns
`default_nettype none
module flash_host_ctrl #(
	parameter int ADDR_W = 20,
	parameter int DATA_W = 16
) (
	input wire logic CLK, // system clock
	input wire logic RESETN, // synchronous reset, low
	input wire logic [3:0] REG_ADDR, // register offset
	input wire logic [31:0] REG_WDATA, // register write data
	input wire logic REG_WR, // write strobe
	input wire logic REG_RD, // read strobe
	output logic [31:0] REG_RDATA, // read data, cycle after strobe
	output logic [ADDR_W-1:0] FL_ADDR, // flash address pins
	input wire logic [DATA_W-1:0] FL_DQ_I, // flash data in
	output logic [DATA_W-1:0] FL_DQ_O, // flash data out
	output logic FL_DQ_OE, // host drives data pins
	output logic FL_CE_N, // chip select
	output logic FL_WE_N, // write strobe
	output logic FL_OE_N, // output gate
	output logic FL_RESET_N, // hardware reset pin
	output logic FL_BYTE_N, // low selects byte mode
	input wire logic FL_DONE_INDICATOR // ready high, busy low
);
	initial
	begin
		if (ADDR_W < 12 || ADDR_W > 32 || DATA_W != 16)
			$error("flash_host_ctrl: unsupported widths");
	end
	typedef enum logic [2:0] {ST_IDLE, ST_ISSUE, ST_WAIT, ST_POLL, ST_RESET} state_t;
	state_t st_q, st_d;
	logic [3:0] op_q, op_d;
	logic [2:0] idx_q, idx_d;
	logic [2:0] len_q, len_d;
	logic [ADDR_W-1:0] tgt_q, tgt_d;
	logic [DATA_W-1:0] wdat_q, wdat_d;
	logic [DATA_W-1:0] rdat_q, rdat_d;
	logic byte_q, byte_d;
	logic busy_q, busy_d;
	logic fail_q, fail_d;
	logic bypass_q, bypass_d;
	logic ident_q, ident_d;
	logic have_prev_q, have_prev_d;
	logic [ADDR_W-1:0] cyc_addr;
	logic [DATA_W-1:0] cyc_data;
	logic cyc_write;
	logic [31:0] rd_d;
	logic [DATA_W-1:0] dq_s1_q, dq_s2_q;
	logic done_s1_q, done_s2_q;
	logic cy_start, cy_busy, cy_done, cy_ce_n, cy_we_n, cy_oe_n, cy_dq_oe;
	logic rst_start, rst_pin, rst_busy;
	logic [ADDR_W-1:0] addr_pin_q;
	logic [DATA_W-1:0] dqo_pin_q;
	logic ce_q, we_q, oe_q, dqoe_q, rstp_q, byten_q;
	logic [11:0] ua, ub;
	flash_bus_cycle #(
		.STROBE_CYCLES(flash_host_pkg::STROBE_CYC),
		.READ_CYCLES(flash_host_pkg::READ_CYC)
	) u_cycle (
		.clk(CLK),
		.resetn(RESETN),
		.start(cy_start),
		.is_write(cyc_write),
		.busy(cy_busy),
		.done(cy_done),
		.ce_n(cy_ce_n),
		.we_n(cy_we_n),
		.oe_n(cy_oe_n),
		.dq_oe(cy_dq_oe)
	);
	flash_reset_timer #(
		.PULSE_CYCLES(flash_host_pkg::RESET_PULSE_CYC),
		.RECOVER_CYCLES(flash_host_pkg::RESET_HIGH_CYC)
	) u_reset (
		.clk(CLK),
		.resetn(RESETN),
		.start(rst_start),
		.reset_n_pin(rst_pin),
		.busy(rst_busy)
	);
	// unlock addresses chosen by bus width
	always_comb
	begin
		ua = byte_q ? flash_host_pkg::ADDR_BYTE_A : flash_host_pkg::ADDR_WORD_A; // [RULE13]
		ub = byte_q ? flash_host_pkg::ADDR_BYTE_B : flash_host_pkg::ADDR_WORD_B; // [RULE13]
	end
	// address/data of the current cycle in each sequence
	always_comb
	begin
		cyc_addr = ADDR_W'(ua);
		cyc_data = DATA_W'(flash_host_pkg::CODE_UNLOCK1);
		cyc_write = 1'b1;
		case (op_q)
			flash_host_pkg::OP_READ, flash_host_pkg::OP_POLL:
			begin
				cyc_addr = tgt_q;
				cyc_write = 1'b0;
			end
			flash_host_pkg::OP_RESET_CMD:
			begin
				cyc_addr = tgt_q; // [RULE21]
				cyc_data = DATA_W'(flash_host_pkg::CODE_RESET); // [RULE9] [RULE20]
			end
			flash_host_pkg::OP_BYPASS_PROGRAM:
				if (idx_q == 3'd0)
					cyc_data = DATA_W'(flash_host_pkg::CODE_PROGRAM); // [RULE2]
				else
				begin
					cyc_addr = tgt_q;
					cyc_data = wdat_q;
				end
			default:
				case (idx_q)
					3'd0: ;
					3'd1, 3'd4:
					begin
						cyc_addr = ADDR_W'(ub);
						cyc_data = DATA_W'(flash_host_pkg::CODE_UNLOCK2);
					end
					3'd2:
						case (op_q)
							flash_host_pkg::OP_PROGRAM:
								cyc_data = DATA_W'(flash_host_pkg::CODE_PROGRAM);
							flash_host_pkg::OP_IDENT:
								cyc_data = DATA_W'(flash_host_pkg::CODE_IDENT); // [RULE4]
							flash_host_pkg::OP_BYPASS_ENTER:
								cyc_data = DATA_W'(flash_host_pkg::CODE_UNLOCK_BYPASS);
							default:
								cyc_data = DATA_W'(flash_host_pkg::CODE_ERASE_SETUP); // [RULE12]
						endcase
					3'd3:
						if (op_q == flash_host_pkg::OP_PROGRAM)
						begin
							cyc_addr = tgt_q;
							cyc_data = wdat_q;
						end
					default:
						if (op_q == flash_host_pkg::OP_CHIP_ERASE)
							cyc_data = DATA_W'(flash_host_pkg::CODE_CHIP_ERASE); // [RULE12]
						else
						begin
							cyc_addr = tgt_q;
							cyc_data = DATA_W'(flash_host_pkg::CODE_SECTOR_ERASE); // [RULE12]
						end
				endcase
		endcase
	end
	// sequencer: one bus cycle per sequence position, then poll after program and erase
	always_comb
	begin
		st_d = st_q;
		op_d = op_q;
		idx_d = idx_q;
		len_d = len_q;
		tgt_d = tgt_q;
		wdat_d = wdat_q;
		rdat_d = rdat_q;
		byte_d = byte_q;
		busy_d = busy_q;
		fail_d = fail_q;
		bypass_d = bypass_q;
		ident_d = ident_q;
		have_prev_d = have_prev_q;
		cy_start = 1'b0;
		rst_start = 1'b0;
		case (st_q)
			ST_IDLE:
				if (REG_WR && REG_ADDR == flash_host_pkg::REG_ADDR)
					tgt_d = REG_WDATA[ADDR_W-1:0];
				else if (REG_WR && REG_ADDR == flash_host_pkg::REG_DATA)
					wdat_d = REG_WDATA[DATA_W-1:0];
				else if (REG_WR && REG_ADDR == flash_host_pkg::REG_CTRL)
				begin
					op_d = REG_WDATA[3:0];
					byte_d = REG_WDATA[flash_host_pkg::CTRL_BYTE_MODE_BIT];
					idx_d = 3'd0;
					busy_d = 1'b1;
					fail_d = 1'b0;
					have_prev_d = 1'b0;
					st_d = ST_ISSUE;
					case (REG_WDATA[3:0])
						flash_host_pkg::OP_READ, flash_host_pkg::OP_POLL,
						flash_host_pkg::OP_RESET_CMD: len_d = 3'd1;
						flash_host_pkg::OP_BYPASS_PROGRAM: len_d = 3'd2; // [RULE2]
						flash_host_pkg::OP_IDENT, flash_host_pkg::OP_BYPASS_ENTER:
							len_d = 3'd3;
						flash_host_pkg::OP_PROGRAM: len_d = 3'd4;
						flash_host_pkg::OP_CHIP_ERASE,
						flash_host_pkg::OP_SECTOR_ERASE: len_d = 3'd6; // [RULE12]
						flash_host_pkg::OP_HW_RESET:
						begin
							len_d = 3'd1;
							st_d = ST_RESET;
						end
						default:
						begin
							busy_d = 1'b0;
							st_d = ST_IDLE;
						end
					endcase
				end
			ST_ISSUE:
			begin
				cy_start = 1'b1;
				st_d = ST_WAIT;
			end
			ST_WAIT:
				if (cy_done)
				begin
					if (!cyc_write)
						rdat_d = dq_s2_q; // [RULE4] [RULE10] [RULE11] [RULE19]
					if (idx_q + 3'd1 < len_q)
					begin
						idx_d = idx_q + 3'd1; // [RULE26]
						st_d = ST_ISSUE;
					end
					else
					begin
						case (op_q)
							flash_host_pkg::OP_IDENT: ident_d = 1'b1; // [RULE24]
							flash_host_pkg::OP_BYPASS_ENTER: bypass_d = 1'b1;
							flash_host_pkg::OP_RESET_CMD:
							begin
								ident_d = 1'b0; // [RULE24]
								bypass_d = 1'b0;
							end
							default: ;
						endcase
						// embedded work started on last strobe rise
						if (op_q == flash_host_pkg::OP_PROGRAM ||
							op_q == flash_host_pkg::OP_BYPASS_PROGRAM ||
							op_q == flash_host_pkg::OP_CHIP_ERASE ||
							op_q == flash_host_pkg::OP_SECTOR_ERASE)
						begin
							op_d = flash_host_pkg::OP_POLL; // [RULE14] [RULE15]
							len_d = 3'd1;
							idx_d = 3'd0;
							st_d = ST_POLL;
						end
						else if (op_q == flash_host_pkg::OP_POLL)
						begin
							// two successive reads with equal toggle bit
							if (have_prev_q &&
								rdat_q[flash_host_pkg::TOGGLE_STATUS_BIT] ==
								dq_s2_q[flash_host_pkg::TOGGLE_STATUS_BIT])
							begin
								busy_d = 1'b0; // [RULE16] [RULE18]
								st_d = ST_IDLE;
							end
							// fail only if both reads carry it: last poll may be array data
							else if (dq_s2_q[flash_host_pkg::TIMEOUT_FAIL_BIT] &&
								have_prev_q && rdat_q[flash_host_pkg::TIMEOUT_FAIL_BIT] &&
								rdat_q[flash_host_pkg::TOGGLE_STATUS_BIT] !=
								dq_s2_q[flash_host_pkg::TOGGLE_STATUS_BIT])
							begin
								fail_d = 1'b1; // [RULE17]
								busy_d = 1'b0;
								st_d = ST_IDLE;
							end
							else
							begin
								have_prev_d = 1'b1;
								st_d = ST_POLL;
							end
						end
						else
						begin
							busy_d = 1'b0;
							st_d = ST_IDLE;
						end
					end
				end
			ST_POLL:
				st_d = ST_ISSUE;
			ST_RESET:
			begin
				rst_start = !rst_busy && idx_q == 3'd0; // [RULE6]
				if (rst_start)
					idx_d = 3'd1;
				else if (idx_q != 3'd0 && !rst_busy && done_s2_q)
				begin
					ident_d = 1'b0; // [RULE7] [RULE8]
					bypass_d = 1'b0;
					busy_d = 1'b0;
					st_d = ST_IDLE;
				end
			end
			default:
				st_d = ST_IDLE;
		endcase
	end
	// register read mux, answer stands the cycle after the strobe
	always_comb
	begin
		rd_d = 32'h0;
		if (REG_RD)
			case (REG_ADDR)
				flash_host_pkg::REG_ADDR: rd_d = 32'(tgt_q);
				flash_host_pkg::REG_DATA: rd_d = 32'(wdat_q);
				flash_host_pkg::REG_RDATA: rd_d = 32'(rdat_q);
				flash_host_pkg::REG_STATUS:
					rd_d = {26'h0, done_s2_q, ident_q, bypass_q, fail_q, 1'b0, busy_q};
				default: rd_d = 32'h0;
			endcase
	end
	always_ff @(posedge CLK)
	begin
		if (!RESETN)
		begin
			st_q <= ST_IDLE;
			op_q <= flash_host_pkg::OP_READ;
			idx_q <= 3'd0;
			len_q <= 3'd0;
			tgt_q <= '0;
			wdat_q <= '0;
			rdat_q <= '0;
			byte_q <= 1'b0;
			busy_q <= 1'b0;
			fail_q <= 1'b0;
			bypass_q <= 1'b0;
			ident_q <= 1'b0;
			have_prev_q <= 1'b0;
			REG_RDATA <= 32'h0;
			dq_s1_q <= '0;
			dq_s2_q <= '0;
			done_s1_q <= 1'b1;
			done_s2_q <= 1'b1;
			addr_pin_q <= '0;
			dqo_pin_q <= '0;
			ce_q <= 1'b1;
			we_q <= 1'b1;
			oe_q <= 1'b1;
			dqoe_q <= 1'b0;
			rstp_q <= 1'b1;
			byten_q <= 1'b1;
		end
		else
		begin
			st_q <= st_d;
			op_q <= op_d;
			idx_q <= idx_d;
			len_q <= len_d;
			tgt_q <= tgt_d;
			wdat_q <= wdat_d;
			rdat_q <= rdat_d;
			byte_q <= byte_d;
			busy_q <= busy_d;
			fail_q <= fail_d;
			bypass_q <= bypass_d;
			ident_q <= ident_d;
			have_prev_q <= have_prev_d;
			REG_RDATA <= rd_d;
			dq_s1_q <= FL_DQ_I;
			dq_s2_q <= dq_s1_q;
			done_s1_q <= FL_DONE_INDICATOR;
			done_s2_q <= done_s1_q;
			addr_pin_q <= cyc_addr;
			dqo_pin_q <= cyc_data;
			ce_q <= cy_ce_n;
			we_q <= cy_we_n; // [RULE1]
			oe_q <= cy_oe_n; // [RULE1] [RULE5]
			dqoe_q <= cy_dq_oe && cy_oe_n; // [RULE5]
			rstp_q <= rst_pin;
			byten_q <= !byte_d;
		end
	end
	assign FL_ADDR = addr_pin_q;
	assign FL_DQ_O = dqo_pin_q;
	assign FL_DQ_OE = dqoe_q;
	assign FL_CE_N = ce_q;
	assign FL_WE_N = we_q;
	assign FL_OE_N = oe_q;
	assign FL_RESET_N = rstp_q;
	assign FL_BYTE_N = byten_q;
endmodule // flash_host_ctrl
`default_nettype wire

// ---- test/flash_host_checker.sv ----
// pin-level assertions for the flash host controller
`timescale 1ns/1ns
`default_nettype none
module flash_host_checker #(
	parameter int ADDR_W = 20,
	parameter int DATA_W = 16
) (
	input wire logic CLK, // clock
	input wire logic RESETN, // reset, low
	input wire logic [ADDR_W-1:0] FL_ADDR, // address
	input wire logic [DATA_W-1:0] FL_DQ_O, // data out
	input wire logic FL_DQ_OE, // data drive
	input wire logic FL_CE_N, // select
	input wire logic FL_WE_N, // write strobe
	input wire logic FL_OE_N, // output gate
	input wire logic FL_RESET_N // reset pin
);
	localparam int PULSE = flash_host_pkg::RESET_PULSE_CYC;
	logic [7:0] low_q;
	logic [7:0] low_d;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESETN);
	always_comb
	begin
		low_d = (!RESETN || FL_RESET_N) ? 8'h00 : low_q + 8'h01;
	end
	always_ff @(posedge CLK)
	begin
		low_q <= low_d;
	end
	sequence wr_tail;
		!FL_WE_N ##1 FL_WE_N;
	endsequence
	sequence rd_tail;
		!FL_OE_N [*2] ##1 FL_OE_N;
	endsequence
	AST_WR_QUAL: assert property (!FL_WE_N |-> !FL_CE_N && FL_OE_N && FL_DQ_OE)
		else $error("write without select, gate or data");
	AST_RD_GATE: assert property (!FL_OE_N |-> !FL_CE_N && FL_WE_N && !FL_DQ_OE)
		else $error("read with host driving data");
	AST_RESET_HOLD: assert property ($rose(FL_RESET_N) |-> low_q >= PULSE)
		else $error("reset pulse too short");
	AST_RESET_QUIET: assert property (!FL_RESET_N |-> FL_WE_N && FL_OE_N)
		else $error("access during reset pulse");
	AST_RESET_TO_READ: assert property ($rose(FL_RESET_N) |-> FL_OE_N [*2])
		else $error("read too soon after reset");
	AST_WR_STABLE: assert property (!FL_WE_N && !$past(FL_WE_N)
		|-> $stable(FL_DQ_O) && $stable(FL_ADDR))
		else $error("write cycle changed mid strobe");
	AST_WR_PULSE: assert property ($fell(FL_WE_N) |=> wr_tail)
		else $error("write strobe length wrong");
	AST_RD_PULSE: assert property ($fell(FL_OE_N) |=> rd_tail)
		else $error("read gate length wrong");
endmodule // flash_host_checker
bind flash_host_ctrl flash_host_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk (.CLK,
	.RESETN, .FL_ADDR, .FL_DQ_O, .FL_DQ_OE, .FL_CE_N, .FL_WE_N, .FL_OE_N, .FL_RESET_N);
`default_nettype wire

// ---- test/flash_dev_model.sv ----
// behavioural parallel flash device, word mode only
`timescale 1ns/1ns
`default_nettype none
module flash_dev_model #(
	parameter int BUSY_READS = 3, // polls before an operation ends
	parameter int READY_NS = 400, // recovery after reset mid operation
	parameter logic [15:0] MAKER_ID = 16'h005a, // arbitrary value
	parameter logic [15:0] DEVICE_ID = 16'h1e3c // arbitrary value
) (
	input wire logic [19:0] addr, // address pins
	input wire logic [15:0] host_dq, // host data
	input wire logic host_oe, // host drives
	input wire logic ce_n, // select
	input wire logic we_n, // write strobe
	input wire logic oe_n, // output gate
	input wire logic reset_n, // reset pin
	input wire logic fail_en, // next erase times out
	output logic [15:0] bus, // resolved data wire
	output logic done // ready high
);
	logic [15:0] mem [256];
	logic [15:0] last, ld, rd;
	logic [19:0] la;
	logic [2:0] step;
	logic ident, bypass, tog, ready, drv, lc;
	int busy;
	initial
	begin
		{step, ident, bypass, tog, ready, last, busy} = '0;
		ready = 1'b1;
		foreach (mem[i]) mem[i] = 16'hffff;
	end
	assign drv = !oe_n && !ce_n && reset_n;
	assign rd = busy != 0 ? {9'h000, tog, busy < 0, 5'h00}
		: ident ? (addr[1] ? {15'h0000, addr[19]}
		: addr[0] ? DEVICE_ID : MAKER_ID) : mem[addr[7:0]];
	// released wire shows a changed value, never a stale one
	assign bus = host_oe ? host_dq : drv ? rd : ~last;
	assign done = busy == 0 && ready;
	always @(bus)
		if (host_oe || drv)
			last = bus;
	always @(negedge reset_n)
	begin
		{step, ident, bypass} = '0;
		if (busy != 0)
		begin
			busy = 0;
			ready = 1'b0;
			#(READY_NS) ready = 1'b1;
		end
	end
	always @(negedge oe_n)
		if (!ce_n && reset_n && busy != 0)
		begin
			tog = ~tog;
			busy = busy > 0 ? busy - 1 : busy;
		end
	always @(negedge we_n)
	begin
		#1;
		la = addr;
		ld = host_dq;
		lc = ce_n;
	end
	task take;
		logic [10:0] a;
		logic [7:0] d;
		a = la[10:0];
		d = ld[7:0];
		if (busy > 0 || busy < 0 && d != 8'hf0)
			return;
		if (step == 3'h3)
		begin
			mem[la[7:0]] = mem[la[7:0]] & ld;
			busy = BUSY_READS;
			step = 3'h0;
		end
		else if (d == 8'hf0)
			{busy, step, ident, bypass} = '0;
		else if (ident)
			step = 3'h0;
		else if (step == 3'h0 && bypass && d == 8'ha0)
			step = 3'h3;
		else if ((step == 3'h0 || step == 3'h4) && a == 11'h555 && d == 8'haa)
			step = step + 3'h1;
		else if ((step == 3'h1 || step == 3'h5) && a == 11'h2aa && d == 8'h55)
			step = step + 3'h1;
		else if (step == 3'h2 && a == 11'h555)
		begin
			step = d == 8'ha0 ? 3'h3 : d == 8'h80 ? 3'h4 : 3'h0;
			ident = d == 8'h90;
			bypass = d == 8'h20;
		end
		else if (step == 3'h6 && (d == 8'h30 || d == 8'h10 && a == 11'h555))
		begin
			step = 3'h0;
			busy = fail_en ? -1 : BUSY_READS;
			foreach (mem[i])
				if (!fail_en && (d == 8'h10 || i[7:4] == la[7:4]))
					mem[i] = 16'hffff;
		end
		else
			step = 3'h0;
	endtask
	// select taken at strobe fall: select may rise in the same step as the strobe
	always @(posedge we_n)
		if (!lc && oe_n && reset_n)
			take();
endmodule // flash_dev_model
`default_nettype wire

// ---- test/testbench.sv ----
// self-checking bench for the flash host controller
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic CLK, RESETN, REG_WR, REG_RD, fail_en;
	logic [3:0] REG_ADDR;
	logic [31:0] REG_WDATA, REG_RDATA, rdat;
	logic [19:0] FL_ADDR, a, p;
	logic [15:0] FL_DQ_I, FL_DQ_O, d;
	logic FL_DQ_OE, FL_CE_N, FL_WE_N, FL_OE_N, FL_RESET_N, FL_DONE_INDICATOR, FL_BYTE_N;
	logic [15:0] shadow [256];
	logic [19:0] ids [5] = '{20'h00000, 20'h00001, 20'h00002, 20'h80002, 20'h7fff0};
	int num_errors, checks_done, seed;
	flash_host_ctrl dut (.CLK, .RESETN, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD,
		.REG_RDATA, .FL_ADDR, .FL_DQ_I, .FL_DQ_O, .FL_DQ_OE, .FL_CE_N, .FL_WE_N,
		.FL_OE_N, .FL_RESET_N, .FL_BYTE_N, .FL_DONE_INDICATOR);
	flash_dev_model dev (.addr(FL_ADDR), .host_dq(FL_DQ_O), .host_oe(FL_DQ_OE),
		.ce_n(FL_CE_N), .we_n(FL_WE_N), .oe_n(FL_OE_N), .reset_n(FL_RESET_N),
		.fail_en(fail_en), .bus(FL_DQ_I), .done(FL_DONE_INDICATOR));
	initial
	begin
		CLK = 1'b0;
		forever #20 CLK = ~CLK;
	end
	function automatic logic [15:0] id_exp(input logic [19:0] ad);
		return ad[1] ? {15'h0000, ad[19]} : ad[0] ? dev.DEVICE_ID : dev.MAKER_ID;
	endfunction
	task print_verdict;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task check(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			num_errors++;
			$display("ERROR %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task reg_wr(input logic [3:0] ad, input logic [31:0] wd);
		@(posedge CLK);
		REG_ADDR <= ad;
		REG_WDATA <= wd;
		REG_WR <= 1'b1;
		@(posedge CLK);
		REG_WR <= 1'b0;
	endtask
	task reg_rd(input logic [3:0] ad);
		@(posedge CLK);
		REG_ADDR <= ad;
		REG_RD <= 1'b1;
		@(posedge CLK);
		REG_RD <= 1'b0;
		@(negedge CLK);
		rdat = REG_RDATA;
	endtask
	task wait_idle;
		for (int n = 0; n < 500; n++)
		begin
			reg_rd(flash_host_pkg::REG_STATUS);
			if (rdat[0] === 1'b0)
				return;
		end
		num_errors++;
		$display("ERROR %0t: busy never cleared", $time);
		print_verdict();
	endtask
	task op(input logic [3:0] code, input logic [19:0] ad, input logic [15:0] wd);
		reg_wr(flash_host_pkg::REG_ADDR, {12'h000, ad});
		reg_wr(flash_host_pkg::REG_DATA, {16'h0000, wd});
		reg_wr(flash_host_pkg::REG_CTRL, {28'h0000000, code});
		wait_idle();
	endtask
	task peek(input logic [19:0] ad, input logic [15:0] exp);
		op(flash_host_pkg::OP_READ, ad, 16'h0000);
		reg_rd(flash_host_pkg::REG_RDATA);
		check(rdat, {16'h0000, exp});
	endtask
	initial
	begin
		seed = 75;
		{num_errors, checks_done} = '0;
		{RESETN, REG_WR, REG_RD, REG_ADDR, REG_WDATA, fail_en} = '0;
		foreach (shadow[i]) shadow[i] = 16'hffff;
		repeat (16) @(posedge CLK);
		RESETN <= 1'b1;
		reg_rd(4'hf);
		reg_rd(flash_host_pkg::REG_STATUS);
		check(rdat & 32'h21, 32'h20);
		reg_wr(flash_host_pkg::REG_CTRL, 32'h00000100);
		wait_idle();
		check({31'h0, FL_BYTE_N}, 32'h0);
		a = 20'($random(seed));
		peek(a, 16'hffff);
		for (int i = 0; i < 8; i++)
		begin
			a = 20'($random(seed));
			d = (i == 0) ? 16'h00f0 : 16'($random(seed));
			p = (i == 0) ? a : p;
			if (i == 4)
			begin
				op(flash_host_pkg::OP_BYPASS_ENTER, 20'h0, 16'h0);
				reg_rd(flash_host_pkg::REG_STATUS);
				check(rdat & 32'h8, 32'h8);
			end
			op(i < 4 ? flash_host_pkg::OP_PROGRAM : flash_host_pkg::OP_BYPASS_PROGRAM, a, d);
			shadow[a[7:0]] = shadow[a[7:0]] & d;
			peek(a, shadow[a[7:0]]);
		end
		op(flash_host_pkg::OP_RESET_CMD, 20'h0, 16'h0);
		op(flash_host_pkg::OP_IDENT, 20'h0, 16'h0);
		foreach (ids[j])
			peek(ids[j], id_exp(ids[j]));
		op(flash_host_pkg::OP_RESET_CMD, 20'($random(seed)), 16'h0);
		peek(a, shadow[a[7:0]]);
		a = p ^ 20'h00040;
		op(flash_host_pkg::OP_SECTOR_ERASE, a, 16'h0);
		foreach (shadow[i])
			shadow[i] = (i[7:4] == a[7:4]) ? 16'hffff : shadow[i];
		peek(a, 16'hffff);
		peek(p, shadow[p[7:0]]);
		op(flash_host_pkg::OP_CHIP_ERASE, 20'h0, 16'h0);
		peek(p, 16'hffff);
		fail_en <= 1'b1;
		op(flash_host_pkg::OP_CHIP_ERASE, 20'h0, 16'h0);
		reg_rd(flash_host_pkg::REG_STATUS);
		check(rdat & 32'h4, 32'h4);
		fail_en <= 1'b0;
		op(flash_host_pkg::OP_RESET_CMD, 20'h0, 16'h0);
		peek(p, 16'hffff);
		op(flash_host_pkg::OP_IDENT, 20'h0, 16'h0);
		op(flash_host_pkg::OP_HW_RESET, 20'h0, 16'h0);
		peek(p, 16'hffff);
		check({31'h0, FL_BYTE_N}, 32'h1);
		print_verdict();
	end
endmodule // testbench
`default_nettype wire
